// file: sesw_core.sv
// Purpose: SPI slave executing status write, array read and page write for a serial EEPROM.
// Assumes: SPI mode 0; chip select high resets the link logic; clock stops between frames.
// Notes: Link captures are frozen while chip select is high and read by the system side then.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Opcodes 01 status, 03 read, 02 write.
// - Only seventeen low address bits matter.
// - Guard pair selects none, quarter, half, all.
// - Status write needs write latch set.
// - Select rise at boundary starts timed cycle.
// - Busy flag reads one during cycle.
// - Write latch clears when cycle ends.
// - New lock and guard bits apply at end.
// - Bits six to four read zero, others kept.
// - Lock bit zero allows status write.
// - Lock set, pin low refuses status writes.
// - Lock mode follows lock bit and pin.
// - Read loads address, shifts byte out.
// - Read address increments, wraps to zero.
// - Select rise ends read at any bit.
// - Read ignored while write cycle runs.
// - Write is opcode, address, data bytes.
// - Page write wraps within the page.
// - Write refused in four listed cases.
// - Cycle erases to zero, then programs.
// - Correction fixes one bit per group.
// - Byte write rewrites whole four-byte group.
module sesw_core
    import sesw_pkg::*;
#(
    parameter int unsigned WRITE_CYCLES = SESW_WRITE_CYCLES
) (
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic spi_clk_in,
    input wire logic spi_cs_n_in,
    input wire logic spi_mosi_in,
    input wire logic protect_n_in,
    input wire logic write_latch_set_in,
    output logic spi_miso_out,
    output logic spi_miso_oe_out,
    output sesw_status_t status_out,
    output logic hardware_lock_mode_out
);
    // Check bits for a 32-bit group, single error correcting Hamming code.
    function automatic logic [5:0] sesw_ecc(input logic [31:0] d);
        logic [5:0] c;
        logic [5:0] p;
        c = '0;
        p = 6'h02;
        for (int i = 0; i < 32; i++) begin
            p = p + 6'h01;
            if ((p & (p - 6'h01)) == 6'h00) begin
                p = p + 6'h01;
            end
            if (d[i]) begin
                c = c ^ p;
            end
        end
        return c;
    endfunction

    // Corrects a single flipped data bit using the stored check bits.
    function automatic logic [31:0] sesw_fix(input logic [31:0] d, input logic [5:0] chk);
        logic [5:0] syn;
        logic [5:0] p;
        logic [31:0] r;
        syn = chk ^ sesw_ecc(d);
        r = d;
        p = 6'h02;
        for (int i = 0; i < 32; i++) begin
            p = p + 6'h01;
            if ((p & (p - 6'h01)) == 6'h00) begin
                p = p + 6'h01;
            end
            if (syn == p) begin
                r[i] = ~d[i];
            end
        end
        return r;
    endfunction

    // Tells whether an address lies in the region chosen by the guard pair.
    function automatic logic sesw_guarded(input logic [16:0] a, input logic [1:0] g);
        logic hit;
        unique case (g)
            2'h0: hit = 1'b0;
            2'h1: hit = (a >= SESW_GUARD_QUARTER);
            2'h2: hit = (a >= SESW_GUARD_HALF);
            2'h3: hit = 1'b1;
        endcase
        return hit;
    endfunction

    logic [7:0] mem [SESW_MEM_BYTES];   // Array bytes, written by the system side only.
    logic [5:0] chk [SESW_GROUPS];      // Check bits per four-byte group.
    logic [7:0] wbuf [256];             // Page write data, written by the link side only.
    logic [255:0] wmask;                // Which page offsets this frame wrote.
    logic [31:0] gbuf [SESW_PAGE_GROUPS]; // Merged groups held between erase and program.

    // Corrected read of one byte, used by the link read path.
    function automatic logic [7:0] sesw_rd(input logic [16:0] a);
        logic [31:0] w;
        w = {mem[{a[16:2], 2'h3}], mem[{a[16:2], 2'h2}], mem[{a[16:2], 2'h1}],
            mem[{a[16:2], 2'h0}]};
        w = sesw_fix(w, chk[a[16:2]]);
        return w[8 * a[1:0] +: 8];
    endfunction

    // Delivered contents: every byte reads as all ones with matching check bits.
    initial begin
        for (int i = 0; i < SESW_MEM_BYTES; i++) begin
            mem[i] = SESW_DELIVERY_BYTE;
        end
        for (int i = 0; i < SESW_GROUPS; i++) begin
            chk[i] = sesw_ecc({4{SESW_DELIVERY_BYTE}});
        end
    end

    // ---------------- Link clock domain ----------------
    sesw_phase_t phase;        // Instruction phase, reset by chip select high.
    logic [2:0] bit_cnt;       // Bit position within the current byte.
    logic [1:0] addr_cnt;      // Address byte counter.
    logic [7:0] shift;         // Incoming serial byte.
    logic [7:0] opcode;        // Opcode of this frame.
    logic [16:0] addr_sr;      // Address shift register, only low bits kept.
    logic [16:0] rd_ptr;       // Next read address.
    logic [7:0] rd_byte;       // Byte being shifted out.
    logic [7:0] wptr;          // Page offset of the next write byte.
    sesw_req_t req;            // Captured request, frozen between frames.
    logic busy_meta;           // Busy flag synchroniser, first stage.
    logic busy_sync;           // Busy flag synchroniser, second stage.
    logic [7:0] next_byte;     // Byte completed at this edge.
    logic byte_done;           // High on the eighth edge of a byte.
    logic [16:0] next_addr;    // Full address completed at this edge.

    assign next_byte = {shift[6:0], spi_mosi_in};
    assign byte_done = (bit_cnt == 3'h7);
    assign next_addr = {addr_sr[15:0], spi_mosi_in};

    // Brings the busy flag into the link domain.
    always_ff @(posedge spi_clk_in) begin
        busy_meta <= status_out.busy;
        busy_sync <= busy_meta;
    end

    // Bit counting and opcode decode; chip select high aborts any frame.
    always_ff @(posedge spi_clk_in or posedge spi_cs_n_in) begin
        if (spi_cs_n_in) begin
            phase <= SESW_PH_OPC;
            bit_cnt <= 3'h0;
            addr_cnt <= 2'h0;
            shift <= 8'h00;
            opcode <= 8'h00;
        end else begin
            bit_cnt <= bit_cnt + 3'h1;
            shift <= next_byte;
            if (byte_done) begin
                unique case (phase)
                    SESW_PH_OPC: begin
                        opcode <= next_byte;
                        // Unknown opcodes leave the device deselected until the frame ends.
                        if (next_byte == SESW_OP_STATUS_WRITE) begin
                            phase <= SESW_PH_STAT;
                        end else if (next_byte == SESW_OP_WRITE) begin
                            phase <= SESW_PH_ADDR;
                        end else if (next_byte == SESW_OP_READ && !busy_sync) begin
                            phase <= SESW_PH_ADDR;
                        end else begin
                            phase <= SESW_PH_IDLE;
                        end
                    end
                    SESW_PH_ADDR: begin
                        addr_cnt <= addr_cnt + 2'h1;
                        if (addr_cnt == SESW_LAST_ADDR_BYTE) begin
                            phase <= (opcode == SESW_OP_READ) ? SESW_PH_READ : SESW_PH_WDATA;
                        end
                    end
                    SESW_PH_STAT: phase <= SESW_PH_IDLE;
                    default: phase <= phase;
                endcase
            end
        end
    end

    // Address capture and read byte fetch with automatic increment.
    always_ff @(posedge spi_clk_in) begin
        if (phase == SESW_PH_ADDR) begin
            addr_sr <= next_addr;
        end
        if (byte_done && phase == SESW_PH_ADDR && addr_cnt == SESW_LAST_ADDR_BYTE) begin
            rd_byte <= sesw_rd(next_addr);
            rd_ptr <= next_addr + 17'h00001;
        end else if (byte_done && phase == SESW_PH_READ) begin
            rd_byte <= sesw_rd(rd_ptr);
            rd_ptr <= rd_ptr + 17'h00001;
        end
    end

    // Page data capture; the offset wraps inside the page.
    always_ff @(posedge spi_clk_in) begin
        if (phase == SESW_PH_OPC && bit_cnt == 3'h0) begin
            wmask <= '0;
        end else if (byte_done && phase == SESW_PH_ADDR && addr_cnt == SESW_LAST_ADDR_BYTE) begin
            wptr <= next_addr[7:0];
        end else if (byte_done && phase == SESW_PH_WDATA) begin
            wbuf[wptr] <= next_byte;
            wmask[wptr] <= 1'b1;
            wptr <= wptr + 8'h01;
        end
    end

    // Request capture; the boundary flag is only true right after a data byte.
    always_ff @(posedge spi_clk_in) begin
        req.boundary_ok <= byte_done &&
            (phase == SESW_PH_STAT || phase == SESW_PH_WDATA);
        if (phase == SESW_PH_OPC && bit_cnt == 3'h0) begin
            // This flop has no reset, so a plain inversion would keep an unknown start value
            // forever. The if form settles it to a known level on the first frame.
            if (req.seq) begin
                req.seq <= 1'b0;
            end else begin
                req.seq <= 1'b1;
            end
            req.kind <= SESW_CMD_NONE;
        end else if (byte_done && phase == SESW_PH_OPC) begin
            if (next_byte == SESW_OP_STATUS_WRITE) begin
                req.kind <= SESW_CMD_STATUS;
            end else if (next_byte == SESW_OP_WRITE) begin
                req.kind <= SESW_CMD_WRITE;
            end
        end
        if (byte_done && phase == SESW_PH_STAT) begin
            req.sdata <= next_byte;
        end
        if (byte_done && phase == SESW_PH_ADDR && addr_cnt == SESW_LAST_ADDR_BYTE) begin
            req.page <= next_addr[16:8];
        end
    end

    // Serial output changes on the falling edge, most significant bit first.
    always_ff @(negedge spi_clk_in or posedge spi_cs_n_in) begin
        if (spi_cs_n_in) begin
            spi_miso_out <= 1'b0;
            spi_miso_oe_out <= 1'b0;
        end else if (phase == SESW_PH_READ) begin
            spi_miso_out <= rd_byte[~bit_cnt];
            spi_miso_oe_out <= 1'b1;
        end else begin
            spi_miso_out <= 1'b0;
            spi_miso_oe_out <= 1'b0;
        end
    end

    // ---------------- System clock domain ----------------
    logic cs_meta;             // Chip select synchroniser, first stage.
    logic cs_sync;             // Chip select synchroniser, second stage.
    logic cs_prev;             // Previous synchronised chip select.
    logic prot_meta;           // Protect pin synchroniser, first stage.
    logic prot_sync;           // Protect pin synchroniser, second stage.
    logic seen_seq;            // Frame sequence already evaluated.
    sesw_sys_t state;          // Write cycle state.
    logic [19:0] timer;        // Cycle time counter.
    logic [5:0] grp;           // Group index within the page.
    logic [8:0] page;          // Page being written.
    logic is_status;           // The running cycle is a status write.
    logic [7:0] pend;          // Pending status value.
    logic frame_end;           // Chip select has just risen after a new frame.
    logic status_take;         // A status write is accepted.
    logic write_take;          // An array write is accepted.
    logic finish;              // Last cycle of the self-timed write.
    logic hw_lock;             // Lock bit set and protect pin low.
    logic [31:0] merged;       // Group contents after merging new bytes.
    logic [16:0] gaddr;        // Byte address of the current group.

    assign frame_end = cs_sync && !cs_prev && (req.seq != seen_seq);
    assign hw_lock = status_out.lock && !prot_sync;
    assign status_take = frame_end && req.kind == SESW_CMD_STATUS && req.boundary_ok
        && status_out.latch && !status_out.busy && !hw_lock;
    assign write_take = frame_end && req.kind == SESW_CMD_WRITE && req.boundary_ok
        && status_out.latch && !status_out.busy
        && !sesw_guarded({req.page, 8'h00}, {status_out.guard_hi, status_out.guard_lo});
    assign finish = (state == SESW_SY_WAIT) && (timer == 20'(WRITE_CYCLES - 1));
    assign gaddr = {page, grp, 2'h0};

    // Old group contents, corrected, with this frame's bytes laid over them.
    always_comb begin
        merged = sesw_fix({mem[gaddr + 17'h3], mem[gaddr + 17'h2], mem[gaddr + 17'h1],
            mem[gaddr]}, chk[gaddr[16:2]]);
        for (int b = 0; b < 4; b++) begin
            if (wmask[{grp, 2'(b)}]) begin
                merged[8 * b +: 8] = wbuf[{grp, 2'(b)}];
            end
        end
    end

    // Synchronisers for chip select and the protect pin.
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            cs_meta <= 1'b1;
            cs_sync <= 1'b1;
            cs_prev <= 1'b1;
            prot_meta <= 1'b1;
            prot_sync <= 1'b1;
        end else begin
            cs_meta <= spi_cs_n_in;
            cs_sync <= cs_meta;
            cs_prev <= cs_sync;
            prot_meta <= protect_n_in;
            prot_sync <= prot_meta;
        end
    end

    // Write cycle sequencer: erase phase, hold, program phase, then wait out the time.
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            state <= SESW_SY_IDLE;
            timer <= 20'h00000;
            grp <= 6'h00;
            page <= 9'h000;
            is_status <= 1'b0;
            pend <= 8'h00;
            seen_seq <= 1'b0;
        end else begin
            if (cs_sync && !cs_prev) begin
                seen_seq <= req.seq;
            end
            timer <= timer + 20'h00001;
            unique case (state)
                SESW_SY_IDLE: begin
                    timer <= 20'h00000;
                    grp <= 6'h00;
                    if (write_take) begin
                        state <= SESW_SY_ERASE;
                        page <= req.page;
                        is_status <= 1'b0;
                    end else if (status_take) begin
                        state <= SESW_SY_WAIT;
                        pend <= req.sdata;
                        is_status <= 1'b1;
                    end
                end
                SESW_SY_ERASE: begin
                    grp <= grp + 6'h01;
                    if (grp == SESW_LAST_GROUP) begin
                        state <= SESW_SY_HOLD;
                    end
                end
                SESW_SY_HOLD: begin
                    if (timer >= 20'(WRITE_CYCLES / 2)) begin
                        state <= SESW_SY_PROG;
                    end
                end
                SESW_SY_PROG: begin
                    grp <= grp + 6'h01;
                    if (grp == SESW_LAST_GROUP) begin
                        state <= SESW_SY_WAIT;
                    end
                end
                SESW_SY_WAIT: begin
                    if (finish) begin
                        state <= SESW_SY_IDLE;
                    end
                end
            endcase
        end
    end

    // Array update: erase writes zeros, program writes the merged group and its check bits.
    always_ff @(posedge clock_in) begin
        if (state == SESW_SY_ERASE && |wmask[{grp, 2'h0} +: 4]) begin
            gbuf[grp] <= merged;
            for (int b = 0; b < 4; b++) begin
                mem[gaddr + 17'(b)] <= SESW_ERASED_BYTE;
            end
            chk[gaddr[16:2]] <= sesw_ecc({4{SESW_ERASED_BYTE}});
        end else if (state == SESW_SY_PROG && |wmask[{grp, 2'h0} +: 4]) begin
            for (int b = 0; b < 4; b++) begin
                mem[gaddr + 17'(b)] <= gbuf[grp][8 * b +: 8];
            end
            chk[gaddr[16:2]] <= sesw_ecc(gbuf[grp]);
        end
    end

    // Status register; a latch set arriving with the end of a cycle wins.
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            status_out <= '0;
        end else begin
            status_out.zero <= 3'h0;
            if (write_take || status_take) begin
                status_out.busy <= 1'b1;
            end else if (finish) begin
                status_out.busy <= 1'b0;
            end
            if (write_latch_set_in) begin
                status_out.latch <= 1'b1;
            end else if (finish) begin
                status_out.latch <= 1'b0;
            end
            if (finish && is_status) begin
                status_out.lock <= pend[SESW_BIT_LOCK];
                status_out.guard_hi <= pend[SESW_BIT_GUARD_HI];
                status_out.guard_lo <= pend[SESW_BIT_GUARD_LO];
            end
        end
    end

    // Hardware lock mode indication.
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            hardware_lock_mode_out <= 1'b0;
        end else begin
            hardware_lock_mode_out <= hw_lock;
        end
    end

    // Checks on the write cycle and protection behaviour.
    sequence write_accept_s;
        write_take;
    endsequence
    sequence lock_attempt_s;
        frame_end && req.kind == SESW_CMD_STATUS && hw_lock && !status_out.busy;
    endsequence

    busy_on_write_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        write_accept_s |=> status_out.busy [*8]) else $error("busy not held after write");
    latch_end_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        (finish && !write_latch_set_in) |=> !status_out.latch && !status_out.busy)
        else $error("latch or busy left set after cycle");
    bits_stable_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        (status_out.busy && !finish) |=> $stable(status_out.lock) && $stable(status_out.guard_hi))
        else $error("lock or guard changed during cycle");
    zero_bits_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        status_out.zero == 3'h0) else $error("reserved status bits nonzero");
    lock_refuse_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        lock_attempt_s |=> !status_out.busy) else $error("status write taken under lock");
    latch_need_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        (frame_end && !status_out.latch && !status_out.busy) |=> !status_out.busy)
        else $error("cycle started without latch");
    hw_lock_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        ##1 hardware_lock_mode_out == $past(status_out.lock && !prot_sync))
        else $error("lock mode indication wrong");
    guard_refuse_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        (frame_end && req.kind == SESW_CMD_WRITE && !status_out.busy &&
        sesw_guarded({req.page, 8'h00}, {status_out.guard_hi, status_out.guard_lo}))
        |=> !status_out.busy) else $error("write into guarded page taken");
    read_busy_a: assert property (@(posedge spi_clk_in) disable iff (spi_cs_n_in)
        (phase == SESW_PH_OPC && byte_done && next_byte == SESW_OP_READ && busy_sync)
        |=> phase == SESW_PH_IDLE) else $error("read accepted while busy");
endmodule

`default_nettype wire

// file: sesw_host.sv
// Purpose: SPI host model that frames instructions for the executor.
// Assumes: Mode 0, 12 ns link clock, still between frames.
// Notes: A released data line shows the inverse of its last bit.
`timescale 1ns/1ps
`default_nettype none
module sesw_host (
    output logic sck_out,
    output logic cs_n_out,
    output logic mosi_out,
    input wire logic miso_in,
    input wire logic oe_in
);
    // Idle bus: deselected, clock low.
    // Chip select makes one real rising edge just after start-up, so the link logic is
    // reset before the first frame.
    initial begin
        sck_out = 1'b0;
        cs_n_out = 1'b0;
        mosi_out = 1'b0;
        #1 cs_n_out = 1'b1;
    end
    // Shifts n bits out MSB first, then samples r bits of reply.
    task automatic frame(input logic [63:0] d, input int n, input int r,
        output logic [15:0] q, output logic oe);
        q = '0;
        oe = 1'b1;
        cs_n_out = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            mosi_out = d[i];
            #6 sck_out = 1'b1;
            #6 sck_out = 1'b0;
        end
        for (int i = 0; i < r; i++) begin
            #6 sck_out = 1'b1;
            q = {q[14:0], miso_in};
            oe = oe & oe_in;
            #6 sck_out = 1'b0;
        end
        #3 cs_n_out = 1'b1;
        mosi_out = ~mosi_out;
        #60;
    endtask
endmodule
`default_nettype wire

// file: sesw_pkg.sv
// Purpose: Shared constants and types for the serial EEPROM instruction executor.
// Assumes: 17-bit byte address space, 256-byte pages, 4-byte correction groups.
// Notes: The write cycle count derives from the write time and the system clock period.
package sesw_pkg;
    // Instruction opcodes, shifted most significant bit first.
    localparam logic [7:0] SESW_OP_STATUS_WRITE = 8'h01;
    localparam logic [7:0] SESW_OP_READ = 8'h03;
    localparam logic [7:0] SESW_OP_WRITE = 8'h02;
    // Address and array geometry.
    localparam int SESW_ADDR_W = 17;
    localparam int SESW_MEM_BYTES = 131072;
    localparam int SESW_GROUPS = 32768;
    localparam int SESW_PAGE_GROUPS = 64;
    localparam logic [5:0] SESW_LAST_GROUP = 6'h3f;
    localparam logic [1:0] SESW_LAST_ADDR_BYTE = 2'h2;
    // Start of each guarded region.
    localparam logic [16:0] SESW_GUARD_QUARTER = 17'h18000;
    localparam logic [16:0] SESW_GUARD_HALF = 17'h10000;
    // Status bit positions.
    localparam int SESW_BIT_BUSY = 0;
    localparam int SESW_BIT_LATCH = 1;
    localparam int SESW_BIT_GUARD_LO = 2;
    localparam int SESW_BIT_GUARD_HI = 3;
    localparam int SESW_BIT_LOCK = 7;
    // Array contents as delivered, and the value of an erased byte.
    localparam logic [7:0] SESW_DELIVERY_BYTE = 8'hff;
    localparam logic [7:0] SESW_ERASED_BYTE = 8'h00;
    // Self-timed write cycle: time in milliseconds, then in clock cycles.
    localparam int SESW_CLK_PERIOD_NS = 10;
    localparam int SESW_WRITE_TIME_MS = 5;
    localparam int SESW_WRITE_CYCLES = SESW_WRITE_TIME_MS * 1000000 / SESW_CLK_PERIOD_NS;

    // Link-side instruction phase.
    typedef enum logic [2:0] {
        SESW_PH_OPC, SESW_PH_ADDR, SESW_PH_STAT, SESW_PH_READ, SESW_PH_WDATA, SESW_PH_IDLE
    } sesw_phase_t;
    // Kind of instruction captured in a frame.
    typedef enum logic [1:0] {SESW_CMD_NONE, SESW_CMD_STATUS, SESW_CMD_WRITE} sesw_cmd_t;
    // System-side write cycle state.
    typedef enum logic [2:0] {SESW_SY_IDLE, SESW_SY_ERASE, SESW_SY_HOLD, SESW_SY_PROG,
        SESW_SY_WAIT} sesw_sys_t;
    // Status register image.
    typedef struct packed {
        logic lock;
        logic [2:0] zero;
        logic guard_hi;
        logic guard_lo;
        logic latch;
        logic busy;
    } sesw_status_t;
    // Request captured by the link side, frozen once chip select is high.
    typedef struct packed {
        sesw_cmd_t kind;
        logic boundary_ok;
        logic seq;
        logic [8:0] page;
        logic [7:0] sdata;
    } sesw_req_t;
endpackage

// file: testbench.sv
// Purpose: Self-checking bench for the EEPROM instruction executor.
// Assumes: Write cycle shortened to 300 clocks.
// Notes: Host model frames all link traffic.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import sesw_pkg::*;
    localparam int WC = 300;
    logic clk, rst_n, prot_n, set_l, sck, cs_n, mosi, miso, oe, hlm, ok;
    sesw_status_t st;
    logic [15:0] q;
    int n_errors = 0;
    int cmp_count = 0;
    int cyc = 0;
    sesw_core #(.WRITE_CYCLES(WC)) i_dut (.clock_in(clk), .rst_n_in(rst_n),
        .spi_clk_in(sck), .spi_cs_n_in(cs_n), .spi_mosi_in(mosi),
        .protect_n_in(prot_n), .write_latch_set_in(set_l), .spi_miso_out(miso),
        .spi_miso_oe_out(oe), .status_out(st), .hardware_lock_mode_out(hlm));
    sesw_host i_host (.sck_out(sck), .cs_n_out(cs_n), .mosi_out(mosi),
        .miso_in(miso), .oe_in(oe));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
        cmp_count++;
        if (s !== e) begin
            n_errors++;
            $display("[ERR] %s exp %h seen %h", nm, e, s);
        end
    endtask
    task automatic close_out;
        if (n_errors == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Cuts a hang short.
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            close_out();
        end
    end
    // One-cycle write-enable pulse.
    task automatic latch;
        @(posedge clk) #1 set_l = 1'b1;
        @(posedge clk) #1 set_l = 1'b0;
    endtask
    // Bounded wait for the write cycle to finish.
    task automatic settle;
        for (int i = 0; i < WC + 50 && st.busy !== 1'b0; i++) @(posedge clk);
        @(posedge clk) #1;
    endtask
    initial begin
        rst_n = 1'b0;
        prot_n = 1'b1;
        set_l = 1'b0;
        repeat (12) @(posedge clk);
        #1 rst_n = 1'b1;
        repeat (3) @(posedge clk);
        chk("status", 16'(st), 16'h0000);
        i_host.frame({8'h01, 8'hf4}, 16, 0, q, ok);
        chk("no latch", 16'(st), 16'h0000);
        latch();
        i_host.frame({8'h01, 8'hf4, 4'h0}, 20, 0, q, ok);
        chk("boundary", 16'(st), 16'h0002);
        i_host.frame({8'h01, 8'hf4}, 16, 0, q, ok);
        chk("pending", 16'(st), 16'h0003);
        i_host.frame({8'h03, 24'h0}, 32, 16, q, ok);
        chk("busy read", {q[14:0], ok}, 16'h0000);
        settle();
        chk("status", 16'(st), 16'h0084);
        prot_n = 1'b0;
        repeat (4) @(posedge clk);
        chk("lock mode", 16'(hlm), 16'h0001);
        latch();
        i_host.frame({8'h01, 8'h00}, 16, 0, q, ok);
        chk("locked", 16'(st), 16'h0086);
        @(posedge clk) #1 prot_n = 1'b1;
        repeat (4) @(posedge clk);
        chk("lock mode", 16'(hlm), 16'h0000);
        i_host.frame({8'h02, 24'h018000, 8'h5a}, 40, 0, q, ok);
        chk("guarded", 16'(st), 16'h0086);
        i_host.frame({8'h02, 24'h0000fe, 24'ha1a2a3}, 56, 0, q, ok);
        settle();
        chk("written", 16'(st), 16'h0084);
        i_host.frame({8'h03, 24'h0000fe}, 32, 16, q, ok);
        chk("page end", q, 16'ha1a2);
        chk("drive", 16'(ok), 16'h0001);
        i_host.frame({8'h03, 24'hfe0000}, 32, 16, q, ok);
        chk("page wrap", q, 16'ha3ff);
        i_host.frame({8'h03, 24'h01ffff}, 32, 12, q, ok);
        chk("roll over", q, 16'h0ffa);
        close_out();
    end
endmodule
`default_nettype wire
